// ---- rtl/bpsrs_defs.vh ----
// constants for the bridge power-state and reset sequencer
// assumes a single 20 MHz sys_clk; included by bare name from the design file
`ifndef BPSRS_DEFS_VH
`define BPSRS_DEFS_VH

// clock period in ns
`define BPSRS_CLK_PERIOD_NS        50
// platform timing, as printed, in their own units
`define BPSRS_PWR_TO_RST_MS        100
`define BPSRS_CLK_TO_RST_US        100
`define BPSRS_FAIL_TO_RST_NS       500
// derived cycle counts (least times round up, longest times round down)
`define BPSRS_PWR_TO_RST_CYC   ((`BPSRS_PWR_TO_RST_MS * 1000000 + `BPSRS_CLK_PERIOD_NS - 1) / `BPSRS_CLK_PERIOD_NS)
`define BPSRS_CLK_TO_RST_CYC   ((`BPSRS_CLK_TO_RST_US * 1000 + `BPSRS_CLK_PERIOD_NS - 1) / `BPSRS_CLK_PERIOD_NS)
`define BPSRS_FAIL_TO_RST_CYC  (`BPSRS_FAIL_TO_RST_NS / `BPSRS_CLK_PERIOD_NS)

// training reset burst length in ordered sets
`define BPSRS_TS1_BURST            1024

// function power state codes
`define BPSRS_D0                   2'h0
`define BPSRS_D3HOT                2'h3
// link power state codes
`define BPSRS_L0                   3'h0
`define BPSRS_L0S                  3'h1
`define BPSRS_L1                   3'h2
`define BPSRS_L23R                 3'h3
`define BPSRS_L3                   3'h4
// bus power state codes
`define BPSRS_B0                   2'h0
`define BPSRS_B1                   2'h1
`define BPSRS_B2                   2'h2
`define BPSRS_B3                   2'h3

`endif

// ---- rtl/bpsrs_core.v ----
// power state tracking, power-event translation and reset sequencing of the bridge
// assumes all inputs synchronous to sys_clk except the fundamental reset pin,
// which is synchronised here; the platform meets its own power/clock timing
`timescale 1ns/1ns
`include "bpsrs_defs.vh"

module bpsrs_core (
  input  wire       sys_clk,
  input  wire       reset,
  input  wire       aux_reset,
  input  wire       fund_reset_n_in,
  input  wire       pci_reset_n,
  input  wire       reverse_bridge_select,
  input  wire [1:0] dstate_req,
  input  wire       dstate_req_valid,
  input  wire       main_power_good,
  input  wire       aspm_enable,
  input  wire       link_idle,
  input  wire       link_l1_req,
  input  wire       link_pme_turn_off,
  input  wire       power_event_request_n_in,
  input  wire       pme_msg_rx,
  input  wire       pme_serviced,
  input  wire       wake_request,
  input  wire       ts1_sent,
  input  wire       sticky_wr,
  input  wire [7:0] sticky_wdata,
  output reg  [1:0] dstate,
  output wire       dstate_cold,
  output reg        dstate_req_unsupported,
  output reg  [2:0] link_state,
  output reg  [1:0] bus_state,
  output reg  [7:0] sticky_data,
  output reg        pme_msg_tx,
  output wire       power_event_request_n_out,
  output wire       power_event_request_n_oe,
  output reg        beacon_tx,
  output wire       func_reset,
  output wire       fund_reset_n_out,
  output wire       fund_reset_n_oe,
  output reg        ts1_reset_tx
);

  // reset sequencer states, one-hot
  localparam [3:0] ST_HOLD  = 4'h1;  // functions held in reset
  localparam [3:0] ST_RUN   = 4'h2;  // functions running
  localparam [3:0] ST_DRIVE = 4'h4;  // reverse: driving reset downstream
  localparam [3:0] ST_TS1   = 4'h8;  // reverse: sending training resets

  reg        rst_sync1_q;     // first synchroniser stage, read only by stage two
  reg        rst_sync2_q;     // synchronised reset-active level
  reg  [3:0] seq_q;           // sequencer state
  reg  [3:0] seq_d;
  reg [10:0] ts1_cnt_q;       // ordered sets sent in the current burst
  reg [10:0] ts1_cnt_d;
  reg        pev_hold_q;      // reverse-mode request held until serviced
  reg        pev_in_q;        // previous sampled request level (inverted pin), for edge detect
  reg        mode_q;          // direction registered from the select pin every cycle

  wire       reverse_mode;
  wire       reset_src;       // active reset request for the current mode
  wire       pev_asserted;

  // the select pin is static; it is registered on every clock once reset lets go
  // sampled every cycle; changing it while running is not supported
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      mode_q <= 1'b0;
    end else begin
      mode_q <= reverse_bridge_select;
    end
  end

  assign reverse_mode = mode_q;

  // two-stage synchroniser: the reset pin has no phase relation to our clock
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rst_sync1_q <= 1'b1;
      rst_sync2_q <= 1'b1;
    end else begin
      rst_sync1_q <= ~fund_reset_n_in;
      rst_sync2_q <= rst_sync1_q;
    end
  end

  // forward mode obeys the fundamental reset, reverse mode the PCI reset
  assign reset_src = reverse_mode ? ~pci_reset_n : rst_sync2_q;

  // sequencer next state
  always @* begin
    seq_d     = seq_q;
    ts1_cnt_d = ts1_cnt_q;
    case (seq_q)
      ST_HOLD: begin
        // startup waits for release; platform timing assumed met
        if (!reset_src) begin
          seq_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (reset_src && reverse_mode) begin
          seq_d     = ST_DRIVE;
          ts1_cnt_d = 11'h000;
        end else if (reset_src) begin
          seq_d = ST_HOLD;
        end
      end
      ST_DRIVE: begin
        // one cycle of downstream reset before the training burst starts
        seq_d = ST_TS1;
      end
      ST_TS1: begin
        // the burst ends on its last set, so 11 bits never wrap
        if (ts1_sent) begin
          ts1_cnt_d = ts1_cnt_q + 11'h001;
        end
        if (ts1_sent && ts1_cnt_q == `BPSRS_TS1_BURST - 1) begin
          seq_d = ST_HOLD;
        end
      end
      default: begin
        seq_d = ST_HOLD;
      end
    endcase
  end

  // sequencer registers
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      seq_q     <= ST_HOLD;
      ts1_cnt_q <= 11'h000;
    end else begin
      seq_q     <= seq_d;
      ts1_cnt_q <= ts1_cnt_d;
    end
  end

  // functions stay in reset outside the run state
  assign func_reset = ~seq_q[1];

  // downstream reset driven only in reverse mode, as open-drain low
  assign fund_reset_n_out = 1'b0;
  assign fund_reset_n_oe  = reverse_mode & (seq_q[0] | seq_q[2] | seq_q[3]);

  // training-reset strobe level towards the link layer
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ts1_reset_tx <= 1'b0;
    end else begin
      ts1_reset_tx <= seq_d[3];
    end
  end

  // function power state; D1/D2 requests are refused and flagged
  // a refused request keeps the old state, so software never sees a half step
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      dstate                 <= `BPSRS_D0;
      dstate_req_unsupported <= 1'b0;
    end else if (func_reset) begin
      dstate                 <= `BPSRS_D0;
      dstate_req_unsupported <= 1'b0;
    end else if (dstate_req_valid) begin
      if (dstate_req == `BPSRS_D0 || dstate_req == `BPSRS_D3HOT) begin
        dstate                 <= dstate_req;
        dstate_req_unsupported <= 1'b0;
      end else begin
        dstate_req_unsupported <= 1'b1;
      end
    end
  end

  // cold is D3 with main power gone
  assign dstate_cold = (dstate == `BPSRS_D3HOT) & ~main_power_good;

  // link power state; ASPM moves between L0 and L0s/L1 while in D0
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      link_state <= `BPSRS_L0;
    end else if (func_reset) begin
      link_state <= main_power_good ? `BPSRS_L0 : `BPSRS_L3;
    end else begin
      case (link_state)
        `BPSRS_L0: begin
          if (link_pme_turn_off) begin
            link_state <= `BPSRS_L23R;
          end else if (dstate == `BPSRS_D3HOT) begin
            link_state <= `BPSRS_L1;
          end else if (aspm_enable && link_l1_req) begin
            link_state <= `BPSRS_L1;
          end else if (aspm_enable && link_idle) begin
            link_state <= `BPSRS_L0S;
          end
        end
        `BPSRS_L0S: begin
          if (!link_idle || !aspm_enable) begin
            link_state <= `BPSRS_L0;
          end
        end
        `BPSRS_L1: begin
          // exit once back in D0 and ASPM no longer asks for L1
          if (dstate == `BPSRS_D0 && !(aspm_enable && link_l1_req)) begin
            link_state <= `BPSRS_L0;
          end else if (link_pme_turn_off) begin
            link_state <= `BPSRS_L23R;
          end
        end
        `BPSRS_L23R: begin
          if (!main_power_good) begin
            link_state <= `BPSRS_L3;
          end
        end
        default: begin
          if (main_power_good) begin
            link_state <= `BPSRS_L0;
          end
        end
      endcase
    end
  end

  // bus power state follows the supplies, the function state and the link state (L1 gives B1)
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      bus_state <= `BPSRS_B0;
    end else if (!main_power_good) begin
      bus_state <= `BPSRS_B3;
    end else if (dstate == `BPSRS_D3HOT) begin
      bus_state <= `BPSRS_B2;
    end else if (link_state == `BPSRS_L1) begin
      bus_state <= `BPSRS_B1;
    end else begin
      bus_state <= `BPSRS_B0;
    end
  end

  // sticky state on the auxiliary reset only, so main resets leave it alone
  always @(posedge sys_clk or posedge aux_reset) begin
    if (aux_reset) begin
      sticky_data <= 8'h00;
    end else if (sticky_wr) begin
      sticky_data <= sticky_wdata;
    end
  end

  // forward mode: a falling edge on the pin becomes one message pulse
  // the edge flop resets to the released level; func_reset holds the message off until the flop has sampled the pin
  assign pev_asserted = ~power_event_request_n_in;
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pev_in_q   <= 1'b0;
      pme_msg_tx <= 1'b0;
    end else begin
      pev_in_q   <= pev_asserted;
      pme_msg_tx <= ~reverse_mode & ~func_reset & pev_asserted & ~pev_in_q;
    end
  end

  // reverse mode: a received message holds the pin low until serviced;
  // a new message in the servicing cycle wins so no event is lost
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pev_hold_q <= 1'b0;
    end else if (!reverse_mode) begin
      pev_hold_q <= 1'b0;
    end else if (pme_msg_rx) begin
      pev_hold_q <= 1'b1;
    end else if (pme_serviced) begin
      pev_hold_q <= 1'b0;
    end
  end

  // open-drain: only ever pull low, float otherwise
  assign power_event_request_n_out = 1'b0;
  assign power_event_request_n_oe  = pev_hold_q;

  // beacon only from L1 and L2/3 ready, in forward mode; there is no wake pin at all
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      beacon_tx <= 1'b0;
    end else begin
      beacon_tx <= wake_request & ~reverse_mode &
                   (link_state == `BPSRS_L23R || link_state == `BPSRS_L1);
    end
  end

endmodule

// ---- verification/bpsrs_platform.sv ----
// platform model: supplies, fundamental reset pin and the pulled-up event pin
// assumes sys_clk also stands for the reference clock while powered; counts scaled
`timescale 1ns/1ns
module bpsrs_platform #(
  parameter PWR_CYC = 40, // scaled power-stable wait
  parameter CLK_CYC = 8   // scaled clock-stable wait and hold
) (
  input  wire sys_clk,
  input  wire power_on,    // bench asks for supplies
  input  wire dev_oe,      // device pulls the event pin
  input  wire ext_pull,    // a pci device pulls the event pin
  output reg  power_good,  // main supplies in range
  output reg  fund_rst_n,  // fundamental reset pin
  output wire pme_pin_n    // resolved event pin
);
  integer on_cnt  = 0;     // cycles since supplies came up
  integer off_cnt = 0;     // cycles since reset asserted at power-off
  // open drain with pull-up: low while any party pulls
  assign pme_pin_n = ~(dev_oe | ext_pull);
  initial begin
    power_good = 1'b0;
    fund_rst_n = 1'b0;
  end
  // release only after power and clock were stable; reset first at power-off
  always @(posedge sys_clk) begin
    if (power_on) begin
      power_good <= 1'b1;
      on_cnt     <= on_cnt + 1;
      off_cnt    <= 0;
      if (on_cnt >= PWR_CYC && on_cnt >= CLK_CYC) fund_rst_n <= 1'b1;
    end else begin
      fund_rst_n <= 1'b0;
      on_cnt     <= 0;
      off_cnt    <= off_cnt + 1;
      if (off_cnt >= CLK_CYC) power_good <= 1'b0;
    end
  end
endmodule

// ---- verification/bpsrs_checker.sv ----
// concurrent checks on the sequencer ports
// assumes one clock domain, bound to every bpsrs_core instance
`timescale 1ns/1ns
module bpsrs_checker (
  input logic       sys_clk,
  input logic       reset,
  input logic       fund_reset_n_in,
  input logic       pci_reset_n,
  input logic       reverse_bridge_select,
  input logic [1:0] dstate_req,
  input logic       dstate_req_valid,
  input logic       power_event_request_n_in,
  input logic       pme_msg_rx,
  input logic       pme_serviced,
  input logic       ts1_sent,
  input logic [1:0] dstate,
  input logic       dstate_req_unsupported,
  input logic       pme_msg_tx,
  input logic       power_event_request_n_out,
  input logic       power_event_request_n_oe,
  input logic       func_reset,
  input logic       fund_reset_n_out,
  input logic       fund_reset_n_oe,
  input logic       ts1_reset_tx
);
  logic [10:0] ts1_cnt_q; // sets sent in the current burst
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  // count burst sets; cleared between bursts
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) ts1_cnt_q <= 11'h000;
    else if (!ts1_reset_tx) ts1_cnt_q <= 11'h000;
    else if (ts1_sent) ts1_cnt_q <= ts1_cnt_q + 11'h001;
  end
  property p_refuse;
    !func_reset && dstate_req_valid && (dstate_req == 2'h1 || dstate_req == 2'h2)
      |=> dstate_req_unsupported && $stable(dstate);
  endproperty
  a_refuse: assert property (p_refuse) else $error("d1/d2 request not refused");
  property p_take;
    !func_reset && dstate_req_valid && (dstate_req == 2'h0 || dstate_req == 2'h3)
      |=> dstate == $past(dstate_req) && !dstate_req_unsupported;
  endproperty
  a_take: assert property (p_take) else $error("d state not taken");
  property p_fwd_pme;
    !reverse_bridge_select && !func_reset && $fell(power_event_request_n_in)
      |=> pme_msg_tx ##1 !pme_msg_tx;
  endproperty
  a_fwd_pme: assert property (p_fwd_pme) else $error("event message missing");
  property p_rev_pme;
    reverse_bridge_select && !func_reset && pme_msg_rx |=> power_event_request_n_oe;
  endproperty
  a_rev_pme: assert property (p_rev_pme) else $error("event pin not pulled");
  property p_rev_hold;
    reverse_bridge_select && power_event_request_n_oe && !pme_serviced && pci_reset_n
      && !func_reset |=> power_event_request_n_oe;
  endproperty
  a_rev_hold: assert property (p_rev_hold) else $error("event pin let go early");
  property p_od;
    !power_event_request_n_out && !fund_reset_n_out;
  endproperty
  a_od: assert property (p_od) else $error("open drain pin driven high");
  property p_fwd_rst;
    !reverse_bridge_select && !fund_reset_n_in |-> ##3 func_reset;
  endproperty
  a_fwd_rst: assert property (p_fwd_rst) else $error("functions not in reset");
  property p_rev_ts1;
    reverse_bridge_select && !func_reset && !pci_reset_n
      |=> func_reset && fund_reset_n_oe ##1 ts1_reset_tx;
  endproperty
  a_rev_ts1: assert property (p_rev_ts1) else $error("reverse reset burst missing");
  property p_ts1_cnt;
    $fell(ts1_reset_tx) |-> ts1_cnt_q == 11'h400;
  endproperty
  a_ts1_cnt: assert property (p_ts1_cnt) else $error("burst length wrong");
  c_refuse: cover property (p_refuse);
  c_rev_pme: cover property (reverse_bridge_select && pme_msg_rx);
  c_ts1: cover property ($fell(ts1_reset_tx));
endmodule
bind bpsrs_core bpsrs_checker i_bpsrs_checker (.*);

// ---- verification/bridge_power_state_and_reset_sequencing_tb.sv ----
// self-checking bench for bpsrs_core with the platform model on its far side
// assumes the checker is bound; run stays near 2200 cycles
`timescale 1ns/1ns
module bridge_power_state_and_reset_sequencing_tb;
  reg        sys_clk = 0, reset = 1, aux_reset = 1, pci_reset_n = 1, sel = 0;
  reg        valid = 0, aspm = 0, l1 = 0, off = 0, rx = 0, svc = 0, wake = 0;
  reg        ts1 = 0, swr = 0, power_on = 0, ext = 0, idle = 0;
  reg  [1:0] req = 0;
  reg  [7:0] sdat = 0;
  wire       fund_n, pgood, pin_n, oe, drv_oe, cold, unsup, pme_tx, bcn, frst, ts1_tx;
  wire [1:0] dstate, bus;
  wire [2:0] link;
  wire [7:0] sticky;
  integer    errors = 0, compares = 0, i, n;
  reg  [2:0] e;
  reg  [1:0] r, pr;
  bpsrs_platform i_bpsrs_platform (.sys_clk(sys_clk), .power_on(power_on), .dev_oe(oe),
    .ext_pull(ext), .power_good(pgood), .fund_rst_n(fund_n), .pme_pin_n(pin_n));
  bpsrs_core i_bpsrs_core (.sys_clk(sys_clk), .reset(reset), .aux_reset(aux_reset),
    .fund_reset_n_in(fund_n), .pci_reset_n(pci_reset_n), .reverse_bridge_select(sel),
    .dstate_req(req), .dstate_req_valid(valid), .main_power_good(pgood),
    .aspm_enable(aspm), .link_idle(idle), .link_l1_req(l1), .link_pme_turn_off(off),
    .power_event_request_n_in(pin_n), .pme_msg_rx(rx), .pme_serviced(svc),
    .wake_request(wake), .ts1_sent(ts1), .sticky_wr(swr), .sticky_wdata(sdat),
    .dstate(dstate), .dstate_cold(cold), .dstate_req_unsupported(unsup),
    .link_state(link), .bus_state(bus), .sticky_data(sticky), .pme_msg_tx(pme_tx),
    .power_event_request_n_out(), .power_event_request_n_oe(oe), .beacon_tx(bcn),
    .func_reset(frst), .fund_reset_n_out(), .fund_reset_n_oe(drv_oe),
    .ts1_reset_tx(ts1_tx));
  initial forever #25 sys_clk = ~sys_clk;
  // refused codes leave the state and raise the flag
  function [2:0] dexp(input [1:0] cur, input [1:0] q);
    dexp = (q == 2'h1 || q == 2'h2) ? {1'b1, cur} : {1'b0, q};
  endfunction
  task chk(input [7:0] seen, input [7:0] exp, input [8*8:1] what);
    compares = compares + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("[FAIL] %0s expected %h seen %h", what, exp, seen);
    end
  endtask
  task nx(input integer k);
    repeat (k) @(posedge sys_clk);
  endtask
  task chn;
    @(negedge sys_clk);
  endtask
  // bounded wait for functions to leave reset
  task run_wait;
    for (n = 0; n < 200 && frst !== 1'b0; n = n + 1) nx(1);
    chn;
    chk(frst, 1'b0, "run");
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #(50 * 20000);
    errors = errors + 1;
    close_out;
  end
  initial begin
    r = 2'($urandom(32'h8e84));
    nx(3);
    reset <= 0;
    aux_reset <= 0;
    power_on <= 1;
    chn;
    chk(frst, 1'b1, "hold");
    run_wait;
    chk(n >= 40, 1'b1, "startup");
    nx(1);
    sdat <= 8'($urandom);
    swr <= 1;
    nx(1);
    swr <= 0;
    reset <= 1;
    nx(1);
    reset <= 0;
    chn;
    chk(sticky, sdat, "sticky");
    run_wait;
    $display("test power up done");
    e = 3'h0;
    // back-to-back requests: every code, then random ones, ending in D0
    for (i = 0; i < 13; i = i + 1) begin
      nx(1);
      pr = r;
      r = (i < 4) ? i[1:0] : (i == 11) ? 2'h0 : 2'($urandom);
      req <= r;
      valid <= (i < 12);
      chn;
      if (i > 0) e = dexp(e[1:0], pr);
      if (i > 0) chk({unsup, dstate}, e, "dstate");
    end
    // pin taken at the next edge; the message stands for one cycle only
    nx(1);
    ext <= 1;
    nx(1);
    chn;
    chk({pin_n, pme_tx}, 2'h1, "pme fwd");
    nx(1);
    ext <= 0;
    chn;
    chk({pme_tx, oe}, 2'h0, "pme one");
    // an idle link drops to L0s first, then busy again with an L1 request
    nx(1);
    aspm <= 1;
    idle <= 1;
    wake <= 1'($urandom);
    nx(1);
    chn;
    chk(link, 3'h1, "aspm l0s");
    nx(1);
    idle <= 0;
    l1 <= 1;
    nx(3);
    chn;
    chk({link, bus}, {3'h2, 2'h1}, "aspm l1");
    chk(bcn, wake, "beacon");
    nx(1);
    off <= 1;
    nx(1);
    off <= 0;
    nx(1);
    chn;
    chk(link, 3'h3, "l23");
    nx(1);
    power_on <= 0;
    nx(4);
    chn;
    chk(frst, 1'b1, "pwr off");
    $display("test forward done");
    nx(1);
    reset <= 1;
    sel <= 1;
    power_on <= 1;
    aux_reset <= 1;
    nx(2);
    reset <= 0;
    aux_reset <= 0;
    chn;
    chk(sticky, 8'h00, "aux clr");
    run_wait;
    nx(1);
    rx <= 1;
    nx(1);
    rx <= 0;
    nx(5);
    chn;
    chk({pin_n, pme_tx}, 2'h0, "pme rev");
    nx(1);
    svc <= 1;
    nx(1);
    svc <= 0;
    nx(1);
    chn;
    chk(pin_n, 1'b1, "pme done");
    // D3 with main supplies gone reads as cold; pci reset stays high here
    nx(1);
    req <= 2'h3;
    valid <= 1;
    nx(1);
    valid <= 0;
    power_on <= 0;
    nx(10);
    chn;
    chk({cold, bus}, {1'b1, 2'h3}, "d3 cold");
    nx(1);
    power_on <= 1;
    nx(1);
    pci_reset_n <= 0;
    nx(3);
    chn;
    chk({frst, drv_oe, ts1_tx}, 3'h7, "ts1 on");
    for (i = 0; i < 2048; i = i + 1) begin
      nx(1);
      ts1 <= ~i[0];
      chn;
      if (i == 2045) chk(ts1_tx, 1'b1, "ts1 1023");
    end
    nx(1);
    chn;
    chk({drv_oe, ts1_tx}, 2'h2, "ts1 end");
    nx(1);
    pci_reset_n <= 1;
    run_wait;
    chk(drv_oe, 1'b0, "rst free");
    $display("test reverse done");
    close_out;
  end
endmodule
